// [rtl/adcc_top.sv]
// Purpose: register file, sequencing and sleep control of a 10-bit converter
// Assumes: sleep and trigger inputs come from logic on CLK; pins are async
// Notes:   APB slave with no wait states; read data is taken in the setup cycle
//
// Design decisions made here: register access over APB and the register offsets.
`timescale 1ns/1ps
module adcc_top (
   input wire logic CLK,
   input wire logic RESET,
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [7:0] PADDR,
   input wire logic [31:0] PWDATA,
   output logic [31:0] PRDATA,
   output logic PREADY,
   output logic PSLVERR,
   input wire logic SLEEP_ACTIVE,
   input wire logic SPECIAL_TRIGGER,
   input wire logic RC_CLK_IN,
   input wire logic COMPARATOR_IN,
   output logic ANALOG_ENABLE,
   output logic SAMPLE_ENABLE,
   output logic [9:0] SAR_TRIAL,
   output logic [11:0] ANALOG_PIN_SEL,
   output logic TEMP_SEL,
   output logic DAC_SEL,
   output logic FVR_SEL,
   output logic NEG_REF_EXT,
   output logic [1:0] POS_REF_SEL,
   output logic CONV_FLAG,
   output logic WAKE_REQUEST,
   output logic TIMER_CLEAR
);

   ////////////////////////////////////////////////////////////////////////////////
   // declarations

   adcc_pkg::adcc_state_t state_ff, nxt_state;
   logic [7:0] control_ff, nxt_control;
   logic [7:0] config_ff, nxt_config;
   logic [7:0] res_high_ff, nxt_res_high;
   logic [7:0] res_low_ff, nxt_res_low;
   logic flag_ff, nxt_flag;
   logic ie_ff, nxt_ie;
   logic power_off_ff, nxt_power_off;
   logic wake_ff, timer_clear_ff;
   logic [3:0] delay_cnt_ff, nxt_delay_cnt;
   logic [31:0] prdata_ff, rd_data;
   logic pslverr_ff;

   logic setup_phase, wr_access;
   logic hit_control, hit_config, hit_high, hit_low, hit_event, hit_any;
   logic wr_control, wr_config, wr_high, wr_low, wr_event;
   logic module_en, go_bit, fmt_right, rc_sel, powered;
   logic sw_go_set, sw_go_clear, sleep_kill, en_lost, go_set, go_clear;
   logic sar_start, sar_abort, sar_busy, sar_sampling, sar_done, sar_load;
   logic [9:0] sar_result;
   logic half_tick;
   logic [4:0] channel;

   ////////////////////////////////////////////////////////////////////////////////
   // APB decode

   // no wait states: the read word is captured in the setup cycle
   assign setup_phase = PSEL & ~PENABLE;
   assign wr_access = PSEL & PENABLE & PWRITE;
   assign hit_control = (PADDR == adcc_pkg::OFS_CONTROL);
   assign hit_config = (PADDR == adcc_pkg::OFS_CONFIG);
   assign hit_high = (PADDR == adcc_pkg::OFS_RESULT_HIGH);
   assign hit_low = (PADDR == adcc_pkg::OFS_RESULT_LOW);
   assign hit_event = (PADDR == adcc_pkg::OFS_EVENT);
   assign hit_any = hit_control | hit_config | hit_high | hit_low | hit_event;
   assign wr_control = wr_access & hit_control;
   assign wr_config = wr_access & hit_config;
   assign wr_high = wr_access & hit_high;
   assign wr_low = wr_access & hit_low;
   assign wr_event = wr_access & hit_event;

   // read mux; unimplemented bits come back zero
   assign rd_data = hit_control ? {24'h00_0000, control_ff & adcc_pkg::CONTROL_WMASK} :
      hit_config ? {24'h00_0000, config_ff & adcc_pkg::CONFIG_WMASK} :
      hit_high ? {24'h00_0000, res_high_ff} :
      hit_low ? {24'h00_0000, res_low_ff} :
      hit_event ? {30'h0000_0000, ie_ff, flag_ff} :
      32'h0000_0000;

   assign PRDATA = prdata_ff;
   assign PREADY = 1'b1;
   assign PSLVERR = pslverr_ff;

   always_ff @(posedge CLK) begin
      if (RESET) begin
         prdata_ff <= 32'h0000_0000;
         pslverr_ff <= 1'b0;
      end else if (setup_phase) begin
         prdata_ff <= rd_data;
         pslverr_ff <= ~hit_any;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // field views

   assign module_en = control_ff[adcc_pkg::EN_BIT];
   assign go_bit = control_ff[adcc_pkg::GO_BIT];
   assign channel = control_ff[adcc_pkg::CH_MSB:adcc_pkg::CH_LSB];
   assign fmt_right = config_ff[adcc_pkg::FM_BIT];
   // enable bit stays set while sleep shuts the analog part down
   assign powered = module_en & ~power_off_ff;

   ////////////////////////////////////////////////////////////////////////////////
   // start and stop conditions

   assign sw_go_set = wr_control & PWDATA[adcc_pkg::GO_BIT] & PWDATA[adcc_pkg::EN_BIT];
   assign sw_go_clear = wr_control & ~PWDATA[adcc_pkg::GO_BIT] & go_bit;
   // a system-derived clock cannot run through sleep
   assign sleep_kill = SLEEP_ACTIVE & ~rc_sel;
   assign en_lost = wr_control & ~PWDATA[adcc_pkg::EN_BIT];
   // trigger needs an enabled module and no non-rc sleep; timing is left to software
   assign go_set = sw_go_set | (SPECIAL_TRIGGER & module_en & ~sleep_kill);
   assign go_clear = sar_done | sw_go_clear | sleep_kill | en_lost;
   assign sar_start = (state_ff == adcc_pkg::ADCC_IDLE && go_bit && powered && !rc_sel) ||
      (state_ff == adcc_pkg::ADCC_DELAY && delay_cnt_ff == adcc_pkg::INSTR_DELAY_LAST
      && go_bit && powered);
   // software clear keeps the partial result; sleep or disable drops it
   assign sar_abort = sw_go_clear | sleep_kill | en_lost;

   ////////////////////////////////////////////////////////////////////////////////
   // control register: software fields and hardware start bit

   always_comb begin
      nxt_control = control_ff;
      if (wr_control) begin
         nxt_control = PWDATA[7:0] & adcc_pkg::CONTROL_WMASK;
         nxt_control[adcc_pkg::GO_BIT] = go_bit;
      end
      if (go_clear) begin
         nxt_control[adcc_pkg::GO_BIT] = 1'b0;
      end
      // a fresh start wins over a finishing conversion in the same cycle
      if (go_set) begin
         nxt_control[adcc_pkg::GO_BIT] = 1'b1;
      end
   end

   assign nxt_config = wr_config ? (PWDATA[7:0] & adcc_pkg::CONFIG_WMASK) : config_ff;

   always_ff @(posedge CLK) begin
      if (RESET) begin
         control_ff <= adcc_pkg::CONTROL_RESET;
         config_ff <= adcc_pkg::CONFIG_RESET;
      end else begin
         control_ff <= nxt_control;
         config_ff <= nxt_config;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // sequencing state machine

   always_comb begin
      nxt_state = state_ff;
      nxt_delay_cnt = 4'h0;
      unique case (state_ff)
         adcc_pkg::ADCC_IDLE: begin
            if (go_bit && powered && !sar_abort) begin
               // rc start is held back so a sleep can execute first
               nxt_state = rc_sel ? adcc_pkg::ADCC_DELAY : adcc_pkg::ADCC_CONV;
            end
         end
         adcc_pkg::ADCC_DELAY: begin
            nxt_delay_cnt = delay_cnt_ff + 4'h1;
            if (sar_abort || !go_bit) begin
               nxt_state = adcc_pkg::ADCC_IDLE;
            end else if (delay_cnt_ff == adcc_pkg::INSTR_DELAY_LAST) begin
               nxt_state = adcc_pkg::ADCC_CONV;
            end
         end
         adcc_pkg::ADCC_CONV: begin
            if (sar_done || sar_abort) begin
               nxt_state = adcc_pkg::ADCC_IDLE;
            end
         end
         default: nxt_state = adcc_pkg::ADCC_IDLE;
      endcase
   end

   always_ff @(posedge CLK) begin
      if (RESET) begin
         state_ff <= adcc_pkg::ADCC_IDLE;
         delay_cnt_ff <= 4'h0;
      end else begin
         state_ff <= nxt_state;
         delay_cnt_ff <= nxt_delay_cnt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // conversion clock and sequencer

   adcc_clkgen u_clkgen (
      .clk(CLK),
      .reset(RESET),
      .run(sar_busy),
      .clock_select(config_ff[adcc_pkg::CS_MSB:adcc_pkg::CS_LSB]),
      .rc_clk_in(RC_CLK_IN),
      .half_tick(half_tick),
      .rc_selected(rc_sel)
   );

   // 3 sample halves plus 10 bits of two halves each
   adcc_sar u_sar (
      .clk(CLK),
      .reset(RESET),
      .start(sar_start),
      .abort(sar_abort),
      .half_tick(half_tick),
      .comp_in(COMPARATOR_IN),
      .busy(sar_busy),
      .sampling(sar_sampling),
      .done(sar_done),
      .load(sar_load),
      .result(sar_result),
      .trial(SAR_TRIAL)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // result registers, loaded one cycle after the sequencer result

   logic load_pend_ff;

   always_comb begin
      nxt_res_high = wr_high ? PWDATA[7:0] : res_high_ff;
      nxt_res_low = wr_low ? PWDATA[7:0] : res_low_ff;
      if (load_pend_ff) begin
         if (fmt_right) begin
            nxt_res_high = {6'h00, sar_result[9:8]};
            nxt_res_low = sar_result[7:0];
         end else begin
            nxt_res_high = sar_result[9:2];
            nxt_res_low = {sar_result[1:0], 6'h00};
         end
      end
   end

   always_ff @(posedge CLK) begin
      if (RESET) begin
         load_pend_ff <= 1'b0;
         res_high_ff <= adcc_pkg::RESULT_RESET;
         res_low_ff <= adcc_pkg::RESULT_RESET;
      end else begin
         load_pend_ff <= sar_load & ~(sleep_kill | en_lost);
         res_high_ff <= nxt_res_high;
         res_low_ff <= nxt_res_low;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // event flag, wake and sleep power-off

   // a completion in the cycle of a software clear still sets the flag
   assign nxt_flag = sar_done | (wr_event ? PWDATA[adcc_pkg::FLAG_BIT] : flag_ff);
   assign nxt_ie = wr_event ? PWDATA[adcc_pkg::IE_BIT] : ie_ff;
   // power-off is released by waking up
   assign nxt_power_off = SLEEP_ACTIVE & (power_off_ff | sleep_kill |
      (sar_done & rc_sel & ~ie_ff));

   always_ff @(posedge CLK) begin
      if (RESET) begin
         flag_ff <= 1'b0;
         ie_ff <= 1'b0;
         power_off_ff <= 1'b0;
         wake_ff <= 1'b0;
         timer_clear_ff <= 1'b0;
      end else begin
         flag_ff <= nxt_flag;
         ie_ff <= nxt_ie;
         power_off_ff <= nxt_power_off;
         wake_ff <= sar_done & SLEEP_ACTIVE & ie_ff;
         timer_clear_ff <= SPECIAL_TRIGGER & module_en & ~sleep_kill;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // analog-side outputs

   assign ANALOG_ENABLE = powered;
   assign SAMPLE_ENABLE = sar_sampling;
   assign CONV_FLAG = flag_ff;
   assign WAKE_REQUEST = wake_ff;
   assign TIMER_CLEAR = timer_clear_ff;
   assign NEG_REF_EXT = config_ff[adcc_pkg::NREF_BIT];
   // reserved code 01 is passed through; the reference module treats it
   assign POS_REF_SEL = config_ff[adcc_pkg::PREF_MSB:adcc_pkg::PREF_LSB];
   assign TEMP_SEL = (channel == adcc_pkg::CH_TEMP);
   assign DAC_SEL = (channel == adcc_pkg::CH_DAC);
   assign FVR_SEL = (channel == adcc_pkg::CH_FVR);

   // codes above the last pin and below the internal sources connect nothing
   genvar p;
   generate
      for (p = 0; p < adcc_pkg::PIN_COUNT; p++) begin : g_pin
         assign ANALOG_PIN_SEL[p] = (channel == 5'(p));
      end
   endgenerate

endmodule

// [rtl/adcc_pkg.sv]
// Purpose: shared constants and types of the converter control block
// Assumes: 20 MHz system clock, APB register access with 32-bit data
// Notes:   register offsets are byte addresses of aligned words
package adcc_pkg;

   ////////////////////////////////////////////////////////////////////////////////
   // clocking and timing
   localparam int unsigned CLK_PERIOD_NS = 50;
   // one instruction cycle of the host processor, in ns
   localparam int unsigned INSTR_CYCLE_NS = 200;
   // least time, so round up to whole clocks
   localparam int unsigned INSTR_DELAY_CYCLES =
      (INSTR_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [3:0] INSTR_DELAY_LAST = 4'(INSTR_DELAY_CYCLES - 1);

   // conversion is counted in half bit-periods: 11.5 periods = 23 halves
   localparam logic [4:0] HALF_SAMPLE = 5'h03;
   localparam logic [4:0] HALF_LAST = 5'h16;
   localparam int unsigned RES_BITS = 10;
   localparam logic [3:0] MSB_INDEX = 4'h9;

   ////////////////////////////////////////////////////////////////////////////////
   // register map
   localparam int unsigned ADDR_W = 8;
   localparam logic [7:0] OFS_CONTROL = 8'h00;
   localparam logic [7:0] OFS_CONFIG = 8'h04;
   localparam logic [7:0] OFS_RESULT_HIGH = 8'h08;
   localparam logic [7:0] OFS_RESULT_LOW = 8'h0C;
   localparam logic [7:0] OFS_EVENT = 8'h10;

   localparam logic [7:0] CONTROL_RESET = 8'h00;
   localparam logic [7:0] CONFIG_RESET = 8'h00;
   localparam logic [7:0] RESULT_RESET = 8'h00;
   localparam logic [7:0] CONTROL_WMASK = 8'h7F;
   localparam logic [7:0] CONFIG_WMASK = 8'hF7;

   // control fields
   localparam int unsigned EN_BIT = 0;
   localparam int unsigned GO_BIT = 1;
   localparam int unsigned CH_LSB = 2;
   localparam int unsigned CH_MSB = 6;
   // configuration fields
   localparam int unsigned PREF_LSB = 0;
   localparam int unsigned PREF_MSB = 1;
   localparam int unsigned NREF_BIT = 2;
   localparam int unsigned CS_LSB = 4;
   localparam int unsigned CS_MSB = 6;
   localparam int unsigned FM_BIT = 7;
   // event register fields
   localparam int unsigned FLAG_BIT = 0;
   localparam int unsigned IE_BIT = 1;

   ////////////////////////////////////////////////////////////////////////////////
   // encodings
   localparam logic [2:0] CS_DIV2 = 3'h0;
   localparam logic [2:0] CS_DIV8 = 3'h1;
   localparam logic [2:0] CS_DIV32 = 3'h2;
   localparam logic [2:0] CS_DIV4 = 3'h4;
   localparam logic [2:0] CS_DIV16 = 3'h5;
   localparam logic [2:0] CS_DIV64 = 3'h6;
   localparam logic [1:0] CS_RC_LOW = 2'h3;

   localparam logic [4:0] CH_PIN_LAST = 5'h0B;
   localparam logic [4:0] CH_TEMP = 5'h1D;
   localparam logic [4:0] CH_DAC = 5'h1E;
   localparam logic [4:0] CH_FVR = 5'h1F;
   localparam int unsigned PIN_COUNT = 12;

   typedef enum logic [2:0] {
      ADCC_IDLE = 3'h1,
      ADCC_DELAY = 3'h2,
      ADCC_CONV = 3'h4
   } adcc_state_t;

endpackage

// [rtl/adcc_clkgen.sv]
// Purpose: conversion clock half-period tick generator
// Assumes: rc clock arrives asynchronously and is far slower than clk
// Notes:   each tick marks one half bit-period of the chosen source
`timescale 1ns/1ps
module adcc_clkgen (
   input wire logic clk,
   input wire logic reset,
   input wire logic run,
   input wire logic [2:0] clock_select,
   input wire logic rc_clk_in,
   output logic half_tick,
   output logic rc_selected
);

   logic rc_meta_ff, rc_sync_ff, rc_prev_ff;
   logic [4:0] div_cnt_ff, nxt_div_cnt;
   logic [4:0] half_last;
   logic div_wrap, rc_edge;

   // half period minus one, in system clocks, per divider code
   always_comb begin
      unique case (clock_select)
         adcc_pkg::CS_DIV2: half_last = 5'h00;
         adcc_pkg::CS_DIV4: half_last = 5'h01;
         adcc_pkg::CS_DIV8: half_last = 5'h03;
         adcc_pkg::CS_DIV16: half_last = 5'h07;
         adcc_pkg::CS_DIV32: half_last = 5'h0F;
         adcc_pkg::CS_DIV64: half_last = 5'h1F;
         default: half_last = 5'h00;
      endcase
   end

   assign rc_selected = (clock_select[1:0] == adcc_pkg::CS_RC_LOW);
   assign div_wrap = (div_cnt_ff == half_last);
   // both rc edges count, as each ends a half period
   assign rc_edge = rc_sync_ff ^ rc_prev_ff;
   assign half_tick = run & (rc_selected ? rc_edge : div_wrap);
   assign nxt_div_cnt = (!run || div_wrap) ? 5'h00 : div_cnt_ff + 5'h01;

   // rc pin passes two flops before the edge detector sees it
   always_ff @(posedge clk) begin
      if (reset) begin
         rc_meta_ff <= 1'b0;
         rc_sync_ff <= 1'b0;
         rc_prev_ff <= 1'b0;
         div_cnt_ff <= 5'h00;
      end else begin
         rc_meta_ff <= rc_clk_in;
         rc_sync_ff <= rc_meta_ff;
         rc_prev_ff <= rc_sync_ff;
         div_cnt_ff <= nxt_div_cnt;
      end
   end

endmodule

// [rtl/adcc_sar.sv]
// Purpose: successive-approximation sequencer for a 10-bit result
// Assumes: comparator high means the input is at or above the trial code
// Notes:   abort fills unconverted bits with the last decided bit
`timescale 1ns/1ps
module adcc_sar (
   input wire logic clk,
   input wire logic reset,
   input wire logic start,
   input wire logic abort,
   input wire logic half_tick,
   input wire logic comp_in,
   output logic busy,
   output logic sampling,
   output logic done,
   output logic load,
   output logic [9:0] result,
   output logic [9:0] trial
);

   logic comp_meta_ff, comp_sync_ff;
   logic busy_ff, last_ff, any_ff;
   logic [4:0] half_cnt_ff;
   logic [3:0] ptr_ff;
   logic [9:0] bits_ff, trial_ff, result_ff;
   logic [9:0] nxt_bits, partial;
   logic decide;

   // a bit is decided at the end of every second half period after sampling
   assign decide = busy_ff & half_tick & (half_cnt_ff > adcc_pkg::HALF_SAMPLE)
      & ~half_cnt_ff[0];
   assign done = decide & (half_cnt_ff == adcc_pkg::HALF_LAST);
   assign load = done | (abort & busy_ff);
   assign busy = busy_ff;
   assign sampling = busy_ff & (half_cnt_ff < adcc_pkg::HALF_SAMPLE);
   assign result = result_ff;
   assign trial = trial_ff;

   genvar i;
   generate
      for (i = 0; i < adcc_pkg::RES_BITS; i++) begin : g_bit
         assign nxt_bits[i] = (decide && ptr_ff == 4'(i)) ? comp_sync_ff : bits_ff[i];
         // unconverted positions copy the last bit, or zero if none yet
         assign partial[i] = (4'(i) < ptr_ff || (4'(i) == ptr_ff && !decide)) ?
            (any_ff & last_ff) : nxt_bits[i];
      end
   endgenerate

   always_ff @(posedge clk) begin
      if (reset) begin
         comp_meta_ff <= 1'b0;
         comp_sync_ff <= 1'b0;
      end else begin
         comp_meta_ff <= comp_in;
         comp_sync_ff <= comp_meta_ff;
      end
   end

   // sequencer state; start restarts from sampling
   always_ff @(posedge clk) begin
      if (reset || abort || done) begin
         busy_ff <= 1'b0;
         half_cnt_ff <= 5'h00;
         ptr_ff <= adcc_pkg::MSB_INDEX;
         trial_ff <= 10'h000;
      end else if (start) begin
         busy_ff <= 1'b1;
         half_cnt_ff <= 5'h00;
         ptr_ff <= adcc_pkg::MSB_INDEX;
         trial_ff <= 10'h200;
      end else if (busy_ff && half_tick) begin
         half_cnt_ff <= half_cnt_ff + 5'h01;
         if (decide) begin
            ptr_ff <= ptr_ff - 4'h1;
            trial_ff <= nxt_bits | (10'h200 >> (adcc_pkg::MSB_INDEX - ptr_ff + 4'h1));
         end
      end
   end

   // decided bits and the result handed to the register file
   always_ff @(posedge clk) begin
      if (reset || start) begin
         bits_ff <= 10'h000;
         last_ff <= 1'b0;
         any_ff <= 1'b0;
      end else if (decide) begin
         bits_ff <= nxt_bits;
         last_ff <= comp_sync_ff;
         any_ff <= 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         result_ff <= 10'h000;
      end else if (load) begin
         result_ff <= done ? nxt_bits : partial;
      end
   end

endmodule

// [verification/adcc_assertions.sv]
// Purpose: port-level checks of the converter control block
// Assumes: one clock domain, synchronous active-high reset
// Notes: bound to the top from the bench file
`timescale 1ns/1ps
module adcc_chk (
   input wire logic CLK,
   input wire logic RESET,
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [31:0] PRDATA,
   input wire logic SLEEP_ACTIVE,
   input wire logic SPECIAL_TRIGGER,
   input wire logic ANALOG_ENABLE,
   input wire logic [11:0] ANALOG_PIN_SEL,
   input wire logic TEMP_SEL,
   input wire logic DAC_SEL,
   input wire logic FVR_SEL,
   input wire logic NEG_REF_EXT,
   input wire logic [1:0] POS_REF_SEL,
   input wire logic CONV_FLAG,
   input wire logic WAKE_REQUEST,
   input wire logic TIMER_CLEAR
);
   default clocking cb @(posedge CLK); endclocking
   default disable iff (RESET);
   // only a completed write may move the reference outputs or clear the flag
   wire logic wr_acc = PSEL && PENABLE && PWRITE;
   ////////////////////////////////////////////////////////////////////////////////
   chk_rdata_upper:
   assert property (PSEL && PENABLE |-> PRDATA[31:8] == 24'h00_0000) else $error("upper read bits set");
   chk_chan_onehot:
   assert property ($onehot0({ANALOG_PIN_SEL, TEMP_SEL, DAC_SEL, FVR_SEL})) else $error("two inputs");
   chk_ref_hold:
   assert property (!wr_acc |=> $stable({NEG_REF_EXT, POS_REF_SEL})) else $error("reference moved");
   chk_flag_hold:
   assert property (CONV_FLAG && !wr_acc |=> CONV_FLAG) else $error("flag dropped by itself");
   chk_timer_cause:
   assert property (TIMER_CLEAR |-> $past(SPECIAL_TRIGGER)) else $error("timer clear without trigger");
   chk_wake_pulse:
   assert property (WAKE_REQUEST |=> !WAKE_REQUEST) else $error("wake longer than one cycle");
   chk_wake_cause:
   assert property (WAKE_REQUEST |-> $past(SLEEP_ACTIVE) ##[0:1] CONV_FLAG) else $error("stray wake");
   chk_power_up:
   assert property ($rose(ANALOG_ENABLE) |-> $past(wr_acc) || $past(SLEEP_ACTIVE, 2))
      else $error("converter powered without cause");
endmodule

// [verification/adcc_tb_top.sv]
// Purpose: self-checking bench of the converter control block
// Assumes: APB slave, comparator held high so results are all ones
// Notes: rc oscillator stand-in toggles every 8 system clocks
`timescale 1ns/1ps
module adcc_tb_top;
   logic CLK, RESET, PSEL, PENABLE, PWRITE, SLEEP_ACTIVE, SPECIAL_TRIGGER, RC_CLK_IN;
   logic COMPARATOR_IN, PREADY, PSLVERR, ANALOG_ENABLE, SAMPLE_ENABLE, TEMP_SEL, DAC_SEL;
   logic FVR_SEL, NEG_REF_EXT, CONV_FLAG, WAKE_REQUEST, TIMER_CLEAR, seen;
   logic [7:0] PADDR;
   logic [31:0] PWDATA, PRDATA, rd;
   logic [9:0] SAR_TRIAL;
   logic [11:0] ANALOG_PIN_SEL;
   logic [1:0] POS_REF_SEL;
   logic [2:0] rc_cnt;
   int n_errors = 0;
   int checked = 0;
   adcc_top dut_u (.CLK(CLK), .RESET(RESET), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
      .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
      .SLEEP_ACTIVE(SLEEP_ACTIVE), .SPECIAL_TRIGGER(SPECIAL_TRIGGER), .RC_CLK_IN(RC_CLK_IN),
      .COMPARATOR_IN(COMPARATOR_IN), .ANALOG_ENABLE(ANALOG_ENABLE), .SAMPLE_ENABLE(SAMPLE_ENABLE),
      .SAR_TRIAL(SAR_TRIAL), .ANALOG_PIN_SEL(ANALOG_PIN_SEL), .TEMP_SEL(TEMP_SEL), .DAC_SEL(DAC_SEL),
      .FVR_SEL(FVR_SEL), .NEG_REF_EXT(NEG_REF_EXT), .POS_REF_SEL(POS_REF_SEL),
      .CONV_FLAG(CONV_FLAG), .WAKE_REQUEST(WAKE_REQUEST), .TIMER_CLEAR(TIMER_CLEAR));
   initial begin
      CLK = 1'b0;
      forever #25 CLK = ~CLK;
   end
   // slow rc source, far below the system clock
   always @(posedge CLK) begin
      rc_cnt <= rc_cnt + 3'h1;
      if (rc_cnt == 3'h7) RC_CLK_IN <= ~RC_CLK_IN;
   end
   ////////////////////////////////////////////////////////////////////////////////
   task finish_test;
      $display("checks %0d mismatches %0d", checked, n_errors);
      if (n_errors == 0 && checked > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
      checked++;
      if (s !== e) begin
         n_errors++;
         $display("MISMATCH %s expected %h seen %h", nm, e, s);
      end
   endtask
   // one transfer; an idle edge follows so the next setup never lands on a release
   task apb(input logic w, input logic [7:0] a, input logic [7:0] d);
      int n;
      {PSEL, PENABLE, PWRITE, PADDR, PWDATA} <= {2'b10, w, a, 24'h00_0000, d};
      @(posedge CLK);
      PENABLE <= 1'b1;
      n = 0;
      do begin @(posedge CLK); n++; end while (PREADY !== 1'b1 && n < 20);
      rd = PRDATA;
      if (n >= 20) begin n_errors++; finish_test(); end
      {PSEL, PENABLE} <= 2'b00;
      @(posedge CLK);
   endtask
   task poll;
      int k;
      k = 0;
      do begin apb(1'b0, 8'h00, 8'h00); k++; end while (rd[1] !== 1'b0 && k < 300);
      if (k >= 300) begin n_errors++; finish_test(); end
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   task t_fields;
      for (int i = 0; i < 4; i++) begin
         apb(1'b0, 8'(4 * i), 8'h00);
         chk("reset value", rd, 32'h0000_0000);
      end
      apb(1'b1, 8'h04, 8'hFF);
      apb(1'b0, 8'h04, 8'h00);
      chk("config", rd, 32'h0000_00F7);
      chk("refs", {NEG_REF_EXT, POS_REF_SEL}, 32'h0000_0007);
      for (int c = 0; c < 32; c++) begin
         apb(1'b1, 8'h00, {1'b1, 5'(c), 2'b00});
         chk("pins", ANALOG_PIN_SEL, (c < 12) ? 32'(1 << c) : 32'h0000_0000);
         chk("inner", {TEMP_SEL, DAC_SEL, FVR_SEL}, 32'({c == 29, c == 30, c == 31}));
         apb(1'b0, 8'h00, 8'h00);
         chk("control", rd, 32'({5'(c), 2'b00}));
      end
      apb(1'b0, 8'h20, 8'h00);
      chk("unmapped", {PSLVERR, rd[30:0]}, 32'h8000_0000);
      $display("test fields done");
   endtask
   task t_conv(input logic [7:0] cfg, input logic [7:0] eh, input logic [7:0] el);
      apb(1'b1, 8'h04, cfg);
      apb(1'b1, 8'h10, 8'h00);
      apb(1'b1, 8'h00, 8'h01);
      apb(1'b1, 8'h00, 8'h03);
      apb(1'b0, 8'h00, 8'h00);
      chk("busy", rd[1], 1'b1);
      poll();
      chk("status", rd[1:0], 2'b01);
      chk("flag", CONV_FLAG, 1'b1);
      apb(1'b0, 8'h08, 8'h00);
      chk("high", rd, 32'(eh));
      apb(1'b0, 8'h0C, 8'h00);
      chk("low", rd, 32'(el));
      $display("test conversion done");
   endtask
   // software stop mid-conversion keeps the bits decided so far
   task t_partial;
      apb(1'b1, 8'h08, 8'h00);
      apb(1'b1, 8'h00, 8'h03);
      @(posedge CLK);
      chk("sample", {SAMPLE_ENABLE, SAR_TRIAL}, 32'h0000_0600);
      repeat (5) @(posedge CLK);
      apb(1'b1, 8'h00, 8'h01);
      apb(1'b0, 8'h08, 8'h00);
      chk("partial", rd, 32'h0000_00FF);
      $display("test partial done");
   endtask
   task t_sleep_abort;
      apb(1'b1, 8'h10, 8'h00);
      apb(1'b1, 8'h00, 8'h03);
      SLEEP_ACTIVE <= 1'b1;
      poll();
      chk("abort", {ANALOG_ENABLE, CONV_FLAG, rd[0]}, 32'h0000_0001);
      SLEEP_ACTIVE <= 1'b0;
      SPECIAL_TRIGGER <= 1'b1;
      @(posedge CLK);
      SPECIAL_TRIGGER <= 1'b0;
      seen = 1'b0;
      repeat (3) begin @(posedge CLK); seen |= TIMER_CLEAR; end
      chk("timer clear", {ANALOG_ENABLE, seen}, 32'h0000_0003);
      apb(1'b0, 8'h00, 8'h00);
      chk("trigger start", rd[1], 1'b1);
      poll();
      $display("test sleep abort done");
   endtask
   // rc clock lets the conversion run on through sleep
   task t_rc(input logic ie);
      int f;
      apb(1'b1, 8'h04, 8'h30);
      apb(1'b1, 8'h10, {6'h00, ie, 1'b0});
      apb(1'b1, 8'h00, 8'h03);
      SLEEP_ACTIVE <= 1'b1;
      seen = 1'b0;
      f = 0;
      for (int k = 0; k < 1000 && f < 4; k++) begin
         @(posedge CLK);
         seen |= WAKE_REQUEST;
         if (CONV_FLAG === 1'b1) f++;
      end
      chk("rc sleep", {f == 4, seen, ANALOG_ENABLE}, 32'({1'b1, ie, ie}));
      apb(1'b0, 8'h00, 8'h00);
      chk("enable kept", rd[1:0], 2'b01);
      SLEEP_ACTIVE <= 1'b0;
      apb(1'b0, 8'h08, 8'h00);
      chk("rc high", rd, 32'h0000_00FF);
      apb(1'b1, 8'h10, 8'h00);
      $display("test rc sleep done");
   endtask
   initial begin
      {RESET, PSEL, PENABLE, PWRITE, SLEEP_ACTIVE, SPECIAL_TRIGGER} = 6'h20;
      {RC_CLK_IN, COMPARATOR_IN, PADDR, PWDATA, rc_cnt} = {2'b01, 40'h00_0000_0000, 3'h0};
      repeat (8) @(posedge CLK);
      RESET <= 1'b0;
      @(posedge CLK);
      t_fields();
      t_conv(8'h80, 8'h03, 8'hFF);
      t_conv(8'h00, 8'hFF, 8'hC0);
      t_partial();
      t_sleep_abort();
      t_rc(1'b1);
      t_rc(1'b0);
      finish_test();
   end
endmodule
bind adcc_top adcc_chk chk_u (.CLK(CLK), .RESET(RESET), .PSEL(PSEL), .PENABLE(PENABLE),
   .PWRITE(PWRITE), .PRDATA(PRDATA), .SLEEP_ACTIVE(SLEEP_ACTIVE), .SPECIAL_TRIGGER(SPECIAL_TRIGGER),
   .ANALOG_ENABLE(ANALOG_ENABLE), .ANALOG_PIN_SEL(ANALOG_PIN_SEL), .TEMP_SEL(TEMP_SEL),
   .DAC_SEL(DAC_SEL), .FVR_SEL(FVR_SEL), .NEG_REF_EXT(NEG_REF_EXT), .POS_REF_SEL(POS_REF_SEL),
   .CONV_FLAG(CONV_FLAG), .WAKE_REQUEST(WAKE_REQUEST), .TIMER_CLEAR(TIMER_CLEAR));
